/* File: startup_output_mode_failsafe.sv */
`timescale 1ns/1ps
module startup_output_mode_failsafe #(
    parameter int unsigned SETTLE_CYCLES = startup_pkg::SETTLE_CYC,
    parameter int unsigned CONFIG_CYCLES = startup_pkg::CONFIG_CYC,
    parameter int unsigned ROM_CYCLES = startup_pkg::ROM_CYC,
    parameter int unsigned START13_CYCLES = startup_pkg::START13_CYC,
    parameter int unsigned START14_CYCLES = startup_pkg::START14_CYC,
    parameter int unsigned WINDOW_CYCLES = startup_pkg::WINDOW_CYC
) (
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // fault detectors, asynchronous
    input wire startup_pkg::fault_t fault_i,
    // configuration loader and rom checker results
    input wire logic sig_ok_i,
    input wire logic rom_ok_i,
    // converter samples
    input wire logic adc_valid_i,
    input wire logic [15:0] adc_bridge_i,
    input wire logic [15:0] adc_temp_i,
    // one-wire decoder
    input wire logic cmd_enter_i,
    input wire logic owi_rd_req_i,
    output logic owi_rd_ack_o,
    output logic owi_rd_nak_o,
    output logic [15:0] owi_rd_data_o,
    // output pin driver
    output logic out_oe_o,
    output logic [11:0] out_code_o,
    output startup_pkg::state_t state_o
);
    import startup_pkg::*;

    core_t r;
    core_t n;

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] wd, input logic [3:0] be,
            input logic [31:0] mask);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                v[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return v & mask;
    endfunction

    function automatic logic signed [47:0] sx(input logic [15:0] v);
        return 48'($signed(v));
    endfunction

    always_comb begin
        logic signed [47:0] s;
        logic signed [47:0] sq;
        logic signed [47:0] cu;
        logic signed [47:0] y;
        logic [14:0] clip;
        logic par_bad;
        logic any_fault;
        logic [31:0] start_cyc;
        mode_t mode;
        fault_t clr;
        logic exit_cmd;
        s = '0;
        sq = '0;
        cu = '0;
        y = '0;
        clip = '0;
        clr = '0;
        exit_cmd = 1'b0;
        par_bad = (^{r.ctrl_w, r.limit_w, r.ofs_w, r.nl_w}) != r.par;
        any_fault = (|r.flt_s2) | par_bad; // R17 R19
        mode = mode_t'(r.ctrl_w[1:0]);
        start_cyc = r.ctrl_w[RES14_BIT] ? 32'(START14_CYCLES)
                                        : 32'(START13_CYCLES);
        n = r;

        // two-stage synchroniser on the asynchronous fault lines
        n.flt_s1 = fault_i;
        n.flt_s2 = r.flt_s1;

        // register writes
        if (r.aw_have && r.w_have && !r.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (r.awaddr)
                CTRL_OFS: begin
                    n.ctrl_w = merge(r.ctrl_w, r.wdata, r.wstrb, CTRL_MASK);
                    exit_cmd = r.wstrb[0] & r.wdata[EXIT_CMD_BIT];
                end
                LIMIT_OFS: begin
                    n.limit_w = merge(r.limit_w, r.wdata, r.wstrb,
                                      LIMIT_MASK);
                end
                OFFSET_TC_OFS: begin
                    n.ofs_w = merge(r.ofs_w, r.wdata, r.wstrb, '1);
                end
                NONLIN_OFS: begin
                    n.nl_w = merge(r.nl_w, r.wdata, r.wstrb, '1);
                end
                STATUS_OFS: begin
                    if (r.wstrb[1]) begin
                        clr = r.wdata[STAT_FLT_LSB +: 8];
                    end
                end
                RESULT_OFS: begin
                    n.bresp = RESP_OKAY;
                end
                default: begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
            // parity follows every legal update; corruption breaks it
            n.par = ^{n.ctrl_w, n.limit_w, n.ofs_w, n.nl_w}; // R18
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s_axi_awvalid && r.awready) begin
            n.aw_have = 1'b1;
            n.awaddr = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_have = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end

        // register reads
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = '0;
            case ({s_axi_araddr[7:2], 2'b00})
                CTRL_OFS: n.rdata = r.ctrl_w;
                LIMIT_OFS: n.rdata = r.limit_w;
                OFFSET_TC_OFS: n.rdata = r.ofs_w;
                NONLIN_OFS: n.rdata = r.nl_w;
                STATUS_OFS: begin
                    n.rdata[2:0] = r.st;
                    n.rdata[STAT_FLT_LSB +: 8] = r.flags;
                    n.rdata[STAT_PAR_BIT] = r.par_err;
                end
                RESULT_OFS: begin
                    n.rdata = (r.st == ST_DIAG) ? 32'(ERR_CODE) // R16
                                                : 32'(r.result); // R8
                end
                default: n.rresp = RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready = !n.w_have && !n.bvalid;
        n.arready = !n.rvalid;

        // sticky fault flags: a new fault wins over its clear
        n.flags = (r.flags & ~clr) | r.flt_s2;
        n.par_err = r.par_err | par_bad;

        // sequencer; counts are mclk cycles at CLK_KHZ, not oscillator periods
        n.cnt = r.cnt + 32'h1; // R11
        case (r.st)
            ST_SETTLE: begin
                if (r.cnt >= 32'(SETTLE_CYCLES - 1)) begin // R1
                    n.st = ST_CONFIG;
                    n.cnt = '0;
                end
            end
            ST_CONFIG: begin
                if (r.cnt >= 32'(CONFIG_CYCLES - 1)) begin // R2
                    n.cnt = '0;
                    if (!sig_ok_i) begin
                        n.st = ST_DIAG; // R6
                    end else if (r.ctrl_w[ROM_EN_BIT]) begin
                        n.st = ST_ROMCHK; // R3
                    end else begin
                        n.st = ST_START;
                    end
                end
            end
            ST_ROMCHK: begin
                if (r.cnt >= 32'(ROM_CYCLES - 1)) begin // R3
                    n.cnt = '0;
                    n.st = rom_ok_i ? ST_START : ST_DIAG; // R6
                end
            end
            ST_START: begin
                if (r.cnt >= start_cyc - 32'h1) begin // R4
                    n.cnt = '0;
                    n.win_open = (mode == OWI_WINDOW_THEN_ANALOG) ||
                                 (mode == ANALOG_WITH_OWI_WINDOW);
                    n.st = (mode == OWI_WINDOW_THEN_ANALOG) ? ST_WINDOW
                                                            : ST_NORMAL;
                end
            end
            ST_WINDOW: begin
                if (cmd_enter_i) begin
                    n.st = ST_COMMAND; // R21
                    n.win_open = 1'b0;
                end else if (r.cnt >= 32'(WINDOW_CYCLES - 1)) begin
                    n.st = ST_NORMAL; // R7 R13
                    n.win_open = 1'b0;
                end
            end
            ST_NORMAL: begin
                if (!r.win_open) begin
                    n.cnt = r.cnt;
                end else if (cmd_enter_i) begin
                    // master overdrove the live analog pin
                    n.st = ST_COMMAND; // R14 R21
                    n.win_open = 1'b0;
                end else if (r.cnt >= 32'(WINDOW_CYCLES - 1)) begin
                    n.win_open = 1'b0;
                end
            end
            ST_COMMAND: begin
                n.cnt = r.cnt;
                if (exit_cmd) begin
                    n.st = ST_NORMAL; // R20
                end
            end
            ST_DIAG: begin
                n.cnt = r.cnt;
            end
            default: begin
                n.st = ST_DIAG;
            end
        endcase
        // diagnostic state is left only through reset
        if (any_fault && r.st != ST_SETTLE) begin
            n.st = ST_DIAG; // R16 R17 R18 R19
            n.win_open = 1'b0;
        end

        // conditioning: offset, temperature, 2nd and 3rd order terms
        if (adc_valid_i && (r.st == ST_NORMAL || r.st == ST_COMMAND)) begin
            s = 48'($signed({1'b0, adc_bridge_i})) - sx(r.ofs_w[15:0])
                - ((sx(r.ofs_w[31:16]) * sx(adc_temp_i)) >>> 15); // R10
            sq = (s * s) >>> 15;
            cu = (sq * s) >>> 15;
            y = s + ((sx(r.nl_w[15:0]) * sq) >>> 15)
                  + ((sx(r.nl_w[31:16]) * cu) >>> 15); // R10
            if (y < 0) begin
                n.result = '0; // R8
            end else if (y > 48'sh7FFF) begin
                n.result = 15'h7FFF; // R8
            end else begin
                n.result = y[14:0];
            end
        end
        clip = n.result;
        if (clip < n.limit_w[14:0]) begin
            clip = n.limit_w[14:0]; // R9
        end
        if (clip > n.limit_w[LIM_HI_LSB +: 15]) begin
            clip = n.limit_w[LIM_HI_LSB +: 15]; // R9
        end

        // pin driver follows the next state
        n.out_code = LDR_CODE;
        case (n.st)
            ST_SETTLE: n.out_oe = 1'b0; // R1
            ST_CONFIG, ST_ROMCHK, ST_DIAG: n.out_oe = 1'b1; // R2 R3 R6
            ST_START: begin
                n.out_oe = (mode == ANALOG_WITH_OWI_WINDOW) ||
                           (mode == ANALOG_ONLY_MODE); // R5
            end
            ST_WINDOW, ST_COMMAND: n.out_oe = 1'b0;
            ST_NORMAL: begin
                n.out_oe = (mode != OWI_ONLY_MODE); // R7 R12
                n.out_code = clip[14:3];
            end
            default: n.out_oe = 1'b1;
        endcase

        // one-wire readout of the conditioned value
        n.owi_ack = 1'b0;
        n.owi_nak = 1'b0;
        if (owi_rd_req_i) begin
            if (mode == ANALOG_ONLY_MODE) begin
                n.owi_nak = 1'b1; // R15
            end else begin
                n.owi_ack = 1'b1; // R12
                n.owi_data = (r.st == ST_DIAG) ? ERR_CODE // R16
                                               : {1'b0, r.result};
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            r <= '0;
            r.ctrl_w <= CTRL_RST;
            r.limit_w <= LIMIT_RST;
            r.ofs_w <= COEF_RST;
            r.nl_w <= COEF_RST;
            r.par <= ^{CTRL_RST, LIMIT_RST, COEF_RST, COEF_RST};
            r.out_code <= LDR_CODE;
        end else if (ce_i) begin
            r <= n;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign owi_rd_ack_o = r.owi_ack;
    assign owi_rd_nak_o = r.owi_nak;
    assign owi_rd_data_o = r.owi_data;
    assign out_oe_o = r.out_oe;
    assign out_code_o = r.out_code;
    assign state_o = r.st;

    logic fault_now;
    logic [31:0] start_len;
    assign fault_now = (|r.flt_s2)
        | ((^{r.ctrl_w, r.limit_w, r.ofs_w, r.nl_w}) != r.par);
    assign start_len = r.ctrl_w[RES14_BIT] ? 32'(START14_CYCLES)
                                           : 32'(START13_CYCLES);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i || !ce_i);

    AST_SETTLE_TRI: assert property ( // R1
        r.st == ST_SETTLE |-> !r.out_oe && r.cnt < 32'(SETTLE_CYCLES))
        else $error("pin driven or settle overrun during settling");
    AST_CONFIG_LDR: assert property ( // R2
        (r.st == ST_CONFIG || r.st == ST_ROMCHK)
            |-> r.out_oe && r.out_code == LDR_CODE)
        else $error("pin not in low range during config or rom check");
    AST_ROM_ONLY_IF_EN: assert property ( // R3
        $rose(r.st == ST_ROMCHK) |-> r.ctrl_w[ROM_EN_BIT])
        else $error("rom check entered while disabled");
    AST_START_HOLD: assert property ( // R4
        (r.st == ST_START && r.cnt < start_len - 32'h1 && !fault_now)
            |=> r.st == ST_START)
        else $error("start routine ended early");
    AST_START_PIN: assert property ( // R5
        (r.st == ST_START && r.ctrl_w[1:0] inside {2'h0, 2'h1})
            |-> !r.out_oe)
        else $error("pin driven in start routine of one-wire mode");
    AST_DIAG_STICKY: assert property ( // R16
        r.st == ST_DIAG |=> r.st == ST_DIAG && r.out_oe
            && r.out_code == LDR_CODE)
        else $error("diagnostic state left or pin not low");
    AST_FAULT_DIAG: assert property ( // R17
        (fault_now && r.st != ST_SETTLE) |=> r.st == ST_DIAG)
        else $error("fault did not raise diagnostic state");
    AST_CLIP: assert property ( // R9
        (r.st == ST_NORMAL && r.out_oe
            && r.limit_w[14:0] <= r.limit_w[30:16])
            |-> r.out_code >= r.limit_w[14:3]
            && r.out_code <= r.limit_w[30:19])
        else $error("analog code outside programmed limits");
    AST_NAK_ANALOG_ONLY: assert property ( // R15
        (owi_rd_req_i && r.ctrl_w[1:0] == 2'h3)
            |=> owi_rd_nak_o && !owi_rd_ack_o)
        else $error("one-wire readout not refused");
    AST_WINDOW_CMD: assert property ( // R21
        (r.st == ST_WINDOW && cmd_enter_i && !fault_now)
            |=> r.st == ST_COMMAND && !r.out_oe)
        else $error("command not taken inside window");
    AST_OWI_ONLY_OFF: assert property ( // R12
        (r.st == ST_NORMAL && r.ctrl_w[1:0] == 2'h0) |-> !r.out_oe)
        else $error("analog output active in one-wire only mode");
endmodule

/* File: startup_pkg.sv */
// Functional notes
// R1: hold reset 500us-2ms, pin tri-stated
// R2: config readout, signature check, pin low_diag_range
// R3: optional 10ms ROM check, pin low_diag_range
// R4: start routine lasts five ADC conversions
// R5: start routine pin depends on one-wire mode
// R6: startup error enters diagnostic_state, pin low
// R7: then measure and output; window precedes analog; ANALOG_WITH_OWI_WINDOW opens the window with the pin driven
// R8: result is unsigned 15-bit fraction, readable
// R9: clip analog result to programmed limits
// R10: remove offset, temperature; correct to third order
// R11: all durations derived from the oscillator clock; the code counts mclk cycles scaled by CLK_KHZ instead
// R12: owi_only_mode: analog off, one-wire readout allowed
// R13: window up to 500ms accepts enter_command_cmd
// R14: master overdrives analog pin to send command
// R15: analog_only_mode: analog on, one-wire readout refused
// R16: any failure: diagnostic_state, pin low, error code
// R17: watchdog or oscillator fault raises diagnostic_state
// R18: memory check errors and register parity fail
// R19: sensor wire, temperature sensor, aging faults fail
// R20: normal, command and diagnostic working states
// R21: command inside window enters command_state
package startup_pkg;
    localparam int unsigned CLK_KHZ = 40_000;
    localparam int unsigned OSC_KHZ = 3_000;
    localparam int unsigned SETTLE_MIN_US = 500;
    localparam int unsigned CONFIG_US = 200;
    localparam int unsigned ROM_CHECK_MS = 10;
    localparam int unsigned WINDOW_MAX_MS = 500;
    localparam int unsigned START_ADC_TIMES = 5;
    localparam int unsigned SETTLE_CYC = SETTLE_MIN_US * CLK_KHZ / 1000;
    localparam int unsigned CONFIG_CYC = CONFIG_US * CLK_KHZ / 1000;
    localparam int unsigned ROM_CYC = ROM_CHECK_MS * CLK_KHZ;
    localparam int unsigned WINDOW_CYC = WINDOW_MAX_MS * CLK_KHZ;
    // conversion time is 2^(res+1) oscillator periods
    localparam int unsigned ADC13_CYC = (2 ** 14) * CLK_KHZ / OSC_KHZ;
    localparam int unsigned ADC14_CYC = (2 ** 15) * CLK_KHZ / OSC_KHZ;
    localparam int unsigned START13_CYC = START_ADC_TIMES * ADC13_CYC;
    localparam int unsigned START14_CYC = START_ADC_TIMES * ADC14_CYC;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] LIMIT_OFS = 8'h04;
    localparam logic [7:0] OFFSET_TC_OFS = 8'h08;
    localparam logic [7:0] NONLIN_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] RESULT_OFS = 8'h14;
    localparam int ROM_EN_BIT = 2;
    localparam int RES14_BIT = 3;
    localparam int EXIT_CMD_BIT = 4;
    localparam int LIM_HI_LSB = 16;
    localparam int STAT_FLT_LSB = 8;
    localparam int STAT_PAR_BIT = 16;
    localparam logic [31:0] CTRL_MASK = 32'h0000_000F;
    localparam logic [31:0] LIMIT_MASK = 32'h7FFF_7FFF;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] LIMIT_RST = 32'h7FFF_0000;
    localparam logic [31:0] COEF_RST = 32'h0000_0000;
    localparam logic [11:0] LDR_CODE = 12'h040;
    localparam logic [15:0] ERR_CODE = 16'h8001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OWI_ONLY_MODE,
        OWI_WINDOW_THEN_ANALOG,
        ANALOG_WITH_OWI_WINDOW,
        ANALOG_ONLY_MODE
    } mode_t;

    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_CONFIG,
        ST_ROMCHK,
        ST_START,
        ST_WINDOW,
        ST_NORMAL,
        ST_COMMAND,
        ST_DIAG
    } state_t;

    typedef struct packed {
        logic wdog;
        logic osc;
        logic nvm;
        logic ram;
        logic wire_break;
        logic wire_short;
        logic temp_sensor;
        logic aging;
    } fault_t;

    typedef struct packed {
        state_t st;
        logic [31:0] cnt;
        logic win_open;
        fault_t flt_s1;
        fault_t flt_s2;
        fault_t flags;
        logic par_err;
        logic [31:0] ctrl_w;
        logic [31:0] limit_w;
        logic [31:0] ofs_w;
        logic [31:0] nl_w;
        logic par;
        logic [14:0] result;
        logic out_oe;
        logic [11:0] out_code;
        logic owi_ack;
        logic owi_nak;
        logic [15:0] owi_data;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } core_t;
endpackage

/* File: owi_master_model.sv */
`timescale 1ns/1ps
module owi_master_model (
    // clock
    input wire logic mclk_i,
    // decoder side
    output logic cmd_enter_o,
    output logic rd_req_o,
    input wire logic ack_i,
    input wire logic nak_i,
    input wire logic [15:0] data_i
);
    initial begin
        cmd_enter_o = 1'b0;
        rd_req_o = 1'b0;
    end
    // caller must only use this while the startup window is open
    task automatic send_cmd();
        @(posedge mclk_i);
        cmd_enter_o <= 1'b1;
        @(posedge mclk_i);
        cmd_enter_o <= 1'b0;
    endtask
    task automatic read(output logic [15:0] d, output logic nak);
        int n;
        d = 'x;
        nak = 'x;
        @(posedge mclk_i);
        rd_req_o <= 1'b1;
        @(posedge mclk_i);
        rd_req_o <= 1'b0;
        // answer stands one cycle only, so look at every cycle
        for (n = 0; n < 4; n++) begin
            @(negedge mclk_i);
            if (ack_i === 1'b1 || nak_i === 1'b1) begin
                d = data_i;
                nak = nak_i;
                break;
            end
        end
    endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import startup_pkg::*;
    localparam int ST_N = 60, CF_N = 10, RM_N = 30, S13_N = 25, WN_N = 40;
    logic mclk_i, rst_i, sig_ok_i, adc_valid_i, awvalid, wvalid, bready;
    logic arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic ack, nak, cmd, rdq, out_oe_o, rom_ok;
    logic [3:0] wstrb;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [15:0] odata, od;
    logic [11:0] out_code_o;
    logic nk;
    fault_t fault_i;
    state_t state_o;
    int fail_count = 0, cmp_count = 0, m, i;

    startup_output_mode_failsafe #(.SETTLE_CYCLES(ST_N),
        .CONFIG_CYCLES(CF_N), .ROM_CYCLES(RM_N), .START13_CYCLES(S13_N),
        .START14_CYCLES(50), .WINDOW_CYCLES(WN_N)) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fault_i(fault_i),
        .sig_ok_i(sig_ok_i), .rom_ok_i(rom_ok), .adc_valid_i(adc_valid_i),
        .adc_bridge_i(16'h1234), .adc_temp_i(16'h0000),
        .cmd_enter_i(cmd), .owi_rd_req_i(rdq), .owi_rd_ack_o(ack),
        .owi_rd_nak_o(nak), .owi_rd_data_o(odata), .out_oe_o(out_oe_o),
        .out_code_o(out_code_o), .state_o(state_o));
    owi_master_model owi (.mclk_i(mclk_i), .cmd_enter_o(cmd),
        .rd_req_o(rdq), .ack_i(ack), .nak_i(nak), .data_i(odata));

    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string s);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic give_up();
        chk(0, 1, "wait timed out");
        summarize();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        give_up();
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk_i);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        give_up();
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        fault_i <= '0;
        sig_ok_i <= 1'b1;
        rom_ok <= 1'b1;
        @(negedge mclk_i);
        chk(out_oe_o, 1'b0, "settle pin");
        @(posedge mclk_i);
    endtask
    task automatic wait_st(input state_t s, input int lim);
        int k;
        for (k = 0; k < lim && state_o !== s; k++) @(negedge mclk_i);
        chk(state_o, s, "state");
    endtask
    // counts the stage length and checks the pin on every cycle of it
    task automatic stage(input state_t s, input int n, input logic oe);
        int c;
        wait_st(s, 300);
        for (c = 0; state_o === s && c < 300; c++) begin
            chk(out_oe_o, oe, "pin enable");
            if (oe) chk(out_code_o, LDR_CODE, "pin code");
            @(negedge mclk_i);
        end
        chk(c, n, "stage length");
    endtask

    initial begin
        {rst_i, sig_ok_i, adc_valid_i, awvalid, wvalid, bready} = '0;
        {arvalid, rready, awaddr, araddr, wdata} = '0;
        fault_i = '0;
        wstrb = 4'hF;
        rom_ok = 1'b1;
        for (m = 0; m < 4; m++) begin
            do_reset();
            if (m == 0) begin
                axi_rd(CTRL_OFS);
                chk(d, CTRL_RST, "ctrl reset");
                axi_rd(8'h20);
                chk(r, RESP_SLVERR, "unmapped read");
                // only byte 0 enabled: the rest of the word must survive
                wstrb <= 4'h1;
                axi_wr(LIMIT_OFS, 32'hFFFF_FF55);
                wstrb <= 4'hF;
                axi_rd(LIMIT_OFS);
                chk(d, 32'h7FFF_0055, "byte write");
            end
            axi_wr(CTRL_OFS, (m == 2) ? 32'(m) | 32'h4 : 32'(m));
            stage(ST_CONFIG, CF_N, 1'b1);
            if (m == 2) stage(ST_ROMCHK, RM_N, 1'b1);
            stage(ST_START, S13_N, m >= 2);
            if (m == 1) stage(ST_WINDOW, WN_N, 1'b0);
            chk(state_o, ST_NORMAL, "normal");
            chk(out_oe_o, m != 0, "normal pin");
            if (m == 0 || m == 3) begin
                owi.read(od, nk);
                chk(nk, m == 3, "readout refusal");
                if (m == 0) chk(od[15], 1'b0, "result sign");
            end
            if (m == 2) begin
                owi.send_cmd();
                @(negedge mclk_i);
                chk(state_o, ST_COMMAND, "command entry");
                chk(out_oe_o, 1'b0, "command pin");
                @(posedge mclk_i);
                axi_wr(CTRL_OFS, 32'h16);
                @(negedge mclk_i);
                chk(state_o, ST_NORMAL, "command exit");
            end
            if (m == 3) begin
                @(posedge mclk_i);
                axi_wr(LIMIT_OFS, 32'h2000_2000);
                adc_valid_i <= 1'b1;
                @(posedge mclk_i);
                adc_valid_i <= 1'b0;
                repeat (2) @(negedge mclk_i);
                chk(out_code_o, 12'h400, "clipped code");
            end
        end
        // every fault_i line, a bad signature and a failed rom check
        for (i = 0; i < 10; i++) begin
            do_reset();
            if (i == 9) begin
                rom_ok <= 1'b0;
                axi_wr(CTRL_OFS, 32'h5);
            end
            wait_st(ST_CONFIG, 200);
            @(posedge mclk_i);
            if (i < 8) fault_i <= fault_t'(8'h01 << i);
            else if (i == 8) sig_ok_i <= 1'b0;
            wait_st(ST_DIAG, 60);
            chk(out_oe_o, 1'b1, "diag pin");
            chk(out_code_o, LDR_CODE, "diag code");
        end
        @(posedge mclk_i);
        axi_rd(RESULT_OFS);
        chk(d, 32'(ERR_CODE), "error code");
        owi.read(od, nk);
        chk(od, ERR_CODE, "one-wire error code");
        summarize();
    end
endmodule
